// ### shared/gateway_defines.vh
/*
  constants for the diagnostic chain to field bus gateway: image sizing,
  master diagnostics bit positions, example slave bit positions, timing.
  assumes inclusion by bare name from the core design file.
*/
`ifndef GATEWAY_DEFINES_VH
`define GATEWAY_DEFINES_VH

`define NODE_COUNT        32
`define SLAVE_MAX         31
`define NODE_IDX_W        5
`define GW_NODE           5'h00
`define IMAGE_WORDS       64
`define WORD_BYTES        2
`define IMAGE_BYTES       64

`define CLK_HZ            125000000
`define TEACH_HOLD_MS     2000
`define FAULT_DELAY_MS    1000
`define FLASH_HALF_MS     250
`define FLASH_COUNT       6

`define MD_IF_FAULT       0
`define MD_INIT_ERR       4
`define MD_TEACH_ERR      5
`define MD_SHORT          6
`define MD_COMM_ERR       7

`define RQ_MAGNET         0
`define RQ_ERR_RESET      7
`define RS_SAFE_OUT       0
`define RS_GUARD_CLOSED   1
`define RS_LOCKED         2
`define RS_INPUT_PAIR     4
`define RS_VALID_ACT      5
`define RS_WARN           6
`define RS_ERROR          7

`define DG_OUT1_FAULT     0
`define DG_OUT2_FAULT     1
`define DG_CROSS_SHORT    2
`define DG_OVER_TEMP      3
`define DG_BAD_ACTUATOR   4
`define DG_INTERNAL       5
`define DG_LINK_ERR       6
`define DG_HANDLE         7

`define FIFO_DEPTH        8
`define FIFO_AW           3
`define REQ_W             13

`endif

// ### core/diag_chain_fieldbus_gateway.v
/*
  gateway core: field bus process image, teach-in control, master diagnostics,
  and a request fifo toward the serial chain engine.
  assumes the chain engine and field bus stack are outside; those inputs on
  the same clock are used directly, the learn button is a raw pin.
*/
// How it works
// - image serves 32 nodes: gateway at index 0 plus 31 chain slaves
// - image holds 64 two-byte words, 32 inputs and 32 outputs
// - output words go to nodes as call-ups, input words carry node responses
// - full image allocated whatever number of slaves is taught in
// - image order follows physical chain order, first slave right after gateway
// - output word low byte is request; input word is response plus diagnostics
// - teach-in required at first start and on count, type or order mismatch
// - completed teach-in flashes the function indicator
// - learn button held 2 seconds starts teach-in; shorter press ignored
// - configuration interface teach trigger acts like the learn button
// - direct-control sends one request byte to one selected node
// - diag bit 0 collective fault, asserted 1 s after detection, data invalid
// - diag bit 4 chain initialisation error, needs power cycle
// - diag bit 5 teach error, chain structure changed in operation
// - diag bit 6 short circuit on chain cable
// - diag bit 7 unreachable slaves, their data marked invalid
// - request bit 7 error reset; response bit 7 error state
// - response bits 0 to 2: safety output, guard closed, locked
// - response bits 4 to 6: input pair, valid actuator, warning; bit 3 unused
// - warning and error bytes share a layout with bits 4 and 6 differing
// - output word: request byte 00 and unused 01; input: response, diagnostics
`timescale 1ns/1ps
`include "gateway_defines.vh"

module req_fifo #(
  parameter WIDTH = 13,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;
  wire [AW-1:0]   rd_nxt;

  // depth is a power of two, so the top count bit alone marks full
  assign in_ready  = ~cnt_q[AW];
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign rd_nxt    = pop ? rd_q + {{(AW-1){1'b0}}, 1'b1} : rd_q;

  // head word sits in its own flop so call_data never ripples through the array mux
  always @(posedge clk) begin
    if (!rst_n) begin
      out_data <= {WIDTH{1'b0}};
    end else if (push && (wr_q == rd_nxt)) begin
      out_data <= in_data;
    end else begin
      out_data <= mem[rd_nxt];
    end
  end

  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

module diag_chain_fieldbus_gateway #(
  parameter [31:0] TEACH_HOLD_CYC = (`CLK_HZ / 1000) * `TEACH_HOLD_MS,
  parameter [31:0] FAULT_DLY_CYC  = (`CLK_HZ / 1000) * `FAULT_DELAY_MS,
  parameter [31:0] FLASH_HALF_CYC = (`CLK_HZ / 1000) * `FLASH_HALF_MS
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // field bus master: output image writes
  input  wire        out_wr,
  input  wire [4:0]  out_node,
  input  wire [15:0] out_word,
  // field bus master: input image reads
  input  wire [4:0]  in_node,
  output reg  [15:0] in_word,
  // chain engine: call-up requests {node, request byte}
  output wire        call_valid,
  input  wire        call_ready,
  output wire [12:0] call_data,
  // chain engine: responses, node index in physical chain order
  input  wire        resp_valid,
  input  wire [4:0]  resp_node,
  input  wire [7:0]  resp_byte,
  input  wire [7:0]  resp_diag,
  input  wire        resp_invalid,
  // chain engine: gateway byte 01 answer and state
  input  wire [7:0]  gw_resp,
  input  wire        chain_fault,
  input  wire        init_error,
  input  wire        structure_changed,
  input  wire        short_circuit,
  input  wire        comm_error,
  input  wire [31:0] unreachable,
  input  wire        config_stored,
  input  wire        config_mismatch,
  // teach-in to chain engine
  output reg         teach_start,
  input  wire        teach_done,
  output wire        teach_required,
  output wire        teach_busy,
  // configuration interface
  input  wire        cfg_teach,
  input  wire        cfg_direct,
  input  wire [4:0]  cfg_node,
  input  wire [7:0]  cfg_byte,
  output wire        cfg_busy,
  // front panel
  input  wire        learn_button,
  output reg         function_indicator,
  // master diagnostics byte
  output reg  [7:0]  master_diag
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_TEACH = 2'b01;
  localparam ST_FLASH = 2'b10;

  // image: 32 output words and 32 input words
  reg [15:0] out_img [0:`NODE_COUNT-1];
  reg [7:0]  rsp_img [0:`NODE_COUNT-1];
  reg [7:0]  dia_img [0:`NODE_COUNT-1];
  reg [31:0] valid_q;

  reg        btn_s1_q;
  reg        btn_s2_q;
  reg [31:0] hold_q;
  reg        held_q;
  reg [31:0] fault_cnt_q;
  reg        fault_q;
  reg [1:0]  st_q;
  reg [31:0] flash_cnt_q;
  reg [3:0]  flash_n_q;
  reg        direct_pend_q;
  reg [12:0] direct_q;

  wire        btn_long;
  wire        teach_trig;
  wire        fifo_in_valid;
  wire        fifo_in_ready;
  wire [12:0] fifo_in_data;

  // master writes own the fifo port, having no ready to wait on; a direct
  // command stays pending on cfg_busy until a cycle with fifo room and no master write
  assign fifo_in_valid = out_wr | direct_pend_q;
  assign fifo_in_data  = out_wr ? {out_node, out_word[7:0]} : direct_q;
  assign cfg_busy      = direct_pend_q;

  req_fifo #(
    .WIDTH (`REQ_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (call_valid),
    .out_ready (call_ready),
    .out_data  (call_data)
  );

  // image stores request words in chain order; bits 0 and 7 pass untouched
  always @(posedge clk) begin
    if (out_wr) begin
      out_img[out_node] <= out_word;
    end
    if (resp_valid) begin
      rsp_img[resp_node] <= resp_byte;
      dia_img[resp_node] <= resp_diag;
    end
  end

  // direct command held until the fifo takes it; a full fifo still drops
  // master writes, so the master must leave it headroom
  always @(posedge clk) begin
    if (!rst_n) begin
      direct_pend_q <= 1'b0;
      direct_q      <= 13'h0000;
    end else if (direct_pend_q) begin
      if (fifo_in_ready && !out_wr) begin
        direct_pend_q <= 1'b0;
      end
    end else if (cfg_direct) begin
      direct_pend_q <= 1'b1;
      direct_q      <= {cfg_node, cfg_byte};
    end
  end

  // per-node validity cleared for unreachable slaves or collective fault
  always @(posedge clk) begin
    if (!rst_n) begin
      valid_q <= 32'h00000000;
    end else begin
      if (resp_valid) begin
        valid_q[resp_node] <= ~resp_invalid;
      end
      if (comm_error) begin
        valid_q <= valid_q & ~unreachable;
      end
      if (fault_q) begin
        valid_q <= 32'h00000000;
      end
    end
  end

  // node 0 is the gateway: master diagnostics plus gateway answer byte
  // nodes marked invalid read as zero so stale data never looks live
  always @(posedge clk) begin
    if (!rst_n) begin
      in_word <= 16'h0000;
    end else if (in_node == `GW_NODE) begin
      in_word <= {gw_resp, master_diag};
    end else if (valid_q[in_node]) begin
      in_word <= {dia_img[in_node], rsp_img[in_node]};
    end else begin
      in_word <= 16'h0000;
    end
  end

  // collective fault only after the condition persists 1 s
  // cycle counters are 32 bits wide: two seconds at the core clock needs 28
  always @(posedge clk) begin
    if (!rst_n) begin
      fault_cnt_q <= 32'h00000000;
      fault_q     <= 1'b0;
    end else if (!chain_fault) begin
      fault_cnt_q <= 32'h00000000;
      fault_q     <= 1'b0;
    end else if (fault_cnt_q >= FAULT_DLY_CYC - 32'h1) begin
      fault_q <= 1'b1;
    end else begin
      fault_cnt_q <= fault_cnt_q + 32'h1;
    end
  end

  // spare bits cleared first, then the defined flags laid over them
  always @(posedge clk) begin
    if (!rst_n) begin
      master_diag <= 8'h00;
    end else begin
      master_diag                <= 8'h00;
      master_diag[`MD_IF_FAULT]  <= fault_q;
      master_diag[`MD_INIT_ERR]  <= init_error;
      master_diag[`MD_TEACH_ERR] <= structure_changed;
      master_diag[`MD_SHORT]     <= short_circuit;
      master_diag[`MD_COMM_ERR]  <= comm_error;
    end
  end

  // button synchroniser and hold timer; a release restarts the count
  // held_q allows one trigger per press however long the button stays down
  always @(posedge clk) begin
    if (!rst_n) begin
      btn_s1_q <= 1'b0;
      btn_s2_q <= 1'b0;
      hold_q   <= 32'h00000000;
      held_q   <= 1'b0;
    end else begin
      btn_s1_q <= learn_button;
      btn_s2_q <= btn_s1_q;
      if (!btn_s2_q) begin
        hold_q <= 32'h00000000;
        held_q <= 1'b0;
      end else if (hold_q < TEACH_HOLD_CYC) begin
        hold_q <= hold_q + 32'h1;
      end else begin
        held_q <= 1'b1;
      end
    end
  end

  assign btn_long       = btn_s2_q & (hold_q >= TEACH_HOLD_CYC) & ~held_q;
  assign teach_trig     = btn_long | cfg_teach;
  assign teach_required = ~config_stored | config_mismatch;
  assign teach_busy     = (st_q == ST_TEACH);

  // teach-in sequencing and completion flash
  always @(posedge clk) begin
    if (!rst_n) begin
      st_q               <= ST_IDLE;
      teach_start        <= 1'b0;
      flash_cnt_q        <= 32'h00000000;
      flash_n_q          <= 4'h0;
      function_indicator <= 1'b0;
    end else begin
      teach_start <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          // slow blink-free steady on while a teach-in is owed
          function_indicator <= teach_required;
          if (teach_trig) begin
            teach_start <= 1'b1;
            st_q        <= ST_TEACH;
          end
        end
        ST_TEACH: begin
          function_indicator <= 1'b0;
          if (teach_done) begin
            st_q        <= ST_FLASH;
            flash_cnt_q <= 32'h00000000;
            flash_n_q   <= 4'h0;
          end
        end
        ST_FLASH: begin
          // a new trigger cuts the flash short rather than being lost
          if (teach_trig) begin
            teach_start        <= 1'b1;
            function_indicator <= 1'b0;
            st_q               <= ST_TEACH;
          end else if (flash_cnt_q >= FLASH_HALF_CYC - 32'h1) begin
            flash_cnt_q        <= 32'h00000000;
            function_indicator <= ~function_indicator;
            if (flash_n_q == `FLASH_COUNT - 1) begin
              st_q <= ST_IDLE;
            end else begin
              flash_n_q <= flash_n_q + 4'h1;
            end
          end else begin
            flash_cnt_q <= flash_cnt_q + 32'h1;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ### verification/gateway_monitor.sv
/* checker for the gateway core: diagnostics byte, call-up stream, teach trigger.
   assumes it is bound to the core and sees only its ports. */
`timescale 1ns/1ps
module gateway_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // requests
  input wire logic        out_wr,
  input wire logic [4:0]  out_node,
  input wire logic [15:0] out_word,
  input wire logic        cfg_direct,
  input wire logic        cfg_busy,
  input wire logic        cfg_teach,
  // call-up stream
  input wire logic        call_valid,
  input wire logic        call_ready,
  input wire logic [12:0] call_data,
  // state
  input wire logic        teach_start,
  input wire logic        teach_busy,
  input wire logic        chain_fault,
  input wire logic        init_error,
  input wire logic        structure_changed,
  input wire logic        short_circuit,
  input wire logic        comm_error,
  input wire logic [7:0]  master_diag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_spare_zero: assert property (master_diag[3:1] == 3'h0)
    else $error("spare diagnostics bits set");
  a_init_flag: assert property (init_error |=> master_diag[4])
    else $error("init flag missing");
  a_teach_flag: assert property (structure_changed |=> master_diag[5])
    else $error("teach error flag missing");
  a_short_flag: assert property (short_circuit |=> master_diag[6])
    else $error("short flag missing");
  a_comm_flag: assert property (comm_error |=> master_diag[7])
    else $error("comm flag missing");
  a_fault_clear: assert property (!chain_fault |-> ##2 !master_diag[0])
    else $error("fault flag without fault");
  // the delay is above eight cycles at any sane setting, ten in the bench
  a_fault_wait: assert property ($rose(chain_fault) |=> !master_diag[0] [*8])
    else $error("fault flag too early");
  a_cfg_teach: assert property (cfg_teach && !teach_busy |=> teach_start)
    else $error("config teach ignored");
  a_call_first: assert property (out_wr && !call_valid && !cfg_busy && !cfg_direct
    |=> call_valid && call_data == {$past(out_node), $past(out_word[7:0])})
    else $error("call-up word wrong");
  a_call_hold: assert property (call_valid && !call_ready
    |=> call_valid && $stable(call_data))
    else $error("call-up dropped while stalled");
endmodule
bind diag_chain_fieldbus_gateway gateway_monitor u_mon (.clk, .rst_n, .out_wr, .out_node,
  .out_word, .cfg_direct, .cfg_busy, .cfg_teach, .call_valid, .call_ready, .call_data,
  .teach_start, .teach_busy, .chain_fault, .init_error, .structure_changed,
  .short_circuit, .comm_error, .master_diag);

// ### verification/chain_engine_model.sv
/* chain engine stand-in: takes call-up words, can stall.
   assumes the bench drives stall and reads the got queue. */
`timescale 1ns/1ps
module chain_engine_model (
  // clock and control
  input  wire logic        clk,
  input  wire logic        stall,
  // call-up stream
  input  wire logic        call_valid,
  output logic             call_ready,
  input  wire logic [12:0] call_data
);
  logic [12:0] got[$];
  initial call_ready = 1'b0;
  // ready moves only after an edge, so a word is never half taken
  always @(posedge clk) begin
    call_ready <= !stall;
    if (call_valid && call_ready) got.push_back(call_data);
  end
endmodule

// ### verification/test_diag_chain_fieldbus_gateway.sv
/* self-checking bench for the gateway core with short timing parameters.
   assumes the checker bind and the chain engine model are compiled first. */
`timescale 1ns/1ps
module test_diag_chain_fieldbus_gateway;
  logic        clk, rst_n, out_wr, resp_valid, resp_invalid, chain_fault, init_error;
  logic        structure_changed, short_circuit, comm_error, config_stored, stall;
  logic        config_mismatch, teach_done, cfg_teach, cfg_direct, learn_button;
  logic        call_valid, call_ready, teach_start, teach_required, teach_busy;
  logic        cfg_busy, function_indicator, ind_q;
  logic [4:0]  out_node, in_node, resp_node, cfg_node;
  logic [7:0]  resp_byte, resp_diag, gw_resp, cfg_byte, master_diag;
  logic [15:0] out_word, in_word, w;
  logic [12:0] call_data;
  logic [31:0] unreachable;
  int          err_count, checks_done, starts, flips;
  diag_chain_fieldbus_gateway #(.TEACH_HOLD_CYC(32'h14), .FAULT_DLY_CYC(32'ha),
    .FLASH_HALF_CYC(32'h4)) u_dut (.clk, .rst_n, .out_wr, .out_node, .out_word, .in_node,
    .in_word, .call_valid, .call_ready, .call_data, .resp_valid, .resp_node, .resp_byte,
    .resp_diag, .resp_invalid, .gw_resp, .chain_fault, .init_error, .structure_changed,
    .short_circuit, .comm_error, .unreachable, .config_stored, .config_mismatch,
    .teach_start, .teach_done, .teach_required, .teach_busy, .cfg_teach, .cfg_direct,
    .cfg_node, .cfg_byte, .cfg_busy, .learn_button, .function_indicator, .master_diag);
  chain_engine_model u_chain (.clk, .stall, .call_valid, .call_ready, .call_data);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    ind_q <= function_indicator;
    if (teach_start === 1'b1) starts++;
    if (function_indicator !== ind_q) flips++;
  end
  task automatic chk(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, seen, exp);
    end
  endtask
  task automatic rd(input logic [4:0] n);
    @(posedge clk) in_node <= n;
    repeat (2) @(posedge clk);
    #1 w = in_word;
  endtask
  task automatic put(input logic [4:0] n, input logic [7:0] b, d, input logic inv);
    @(posedge clk) begin
      resp_valid <= 1'b1;
      resp_node <= n;
      resp_byte <= b;
      resp_diag <= d;
      resp_invalid <= inv;
    end
    @(posedge clk) resp_valid <= 1'b0;
  endtask
  task automatic t_image;
    gw_resp <= 8'h3c;
    put(5'h01, 8'h25, 8'h81, 1'b0);
    put(5'h1f, 8'hc7, 8'h10, 1'b0);
    put(5'h03, 8'h66, 8'h02, 1'b1);
    rd(5'h01);
    chk(w, 32'h8125, "first slave");
    rd(5'h1f);
    chk(w, 32'h10c7, "last slave");
    rd(5'h03);
    chk(w, 32'h0, "invalid slave");
    rd(5'h00);
    chk(w, 32'h3c00, "gateway word");
    $display("done image");
  endtask
  task automatic t_calls;
    @(posedge clk) stall <= 1'b1;
    for (int i = 1; i <= 9; i++) begin
      @(posedge clk) out_wr <= 1'b1;
      out_node <= i[4:0];
      out_word <= {8'hee, i[7:0] + 8'h10};
    end
    @(posedge clk) out_wr <= 1'b0;
    repeat (3) @(posedge clk);
    chk(call_valid, 32'h1, "head while stalled");
    stall <= 1'b0;
    repeat (20) @(posedge clk);
    chk(u_chain.got.size(), 32'h8, "fifo depth");
    for (int i = 0; i < 8; i++)
      chk(u_chain.got[i], {i[4:0] + 5'h01, i[7:0] + 8'h11}, "call order");
    cfg_direct <= 1'b1;
    cfg_node <= 5'h1f;
    cfg_byte <= 8'h5a;
    @(posedge clk) cfg_direct <= 1'b0;
    #1 chk(cfg_busy, 32'h1, "direct pending");
    repeat (10) @(posedge clk);
    chk(u_chain.got[8], {5'h1f, 8'h5a}, "direct call");
    chk(cfg_busy, 32'h0, "direct taken");
    $display("done calls");
  endtask
  task automatic t_diag;
    put(5'h02, 8'h11, 8'h22, 1'b0);
    comm_error <= 1'b1;
    unreachable <= 32'h4;
    rd(5'h02);
    chk(w, 32'h0, "unreachable slave");
    rd(5'h01);
    chk(w, 32'h8125, "reachable slave");
    @(posedge clk) {init_error, structure_changed, short_circuit, chain_fault} <= 4'hf;
    repeat (5) @(posedge clk);
    #1 chk(master_diag, 32'hf0, "flags, fault pending");
    repeat (10) @(posedge clk);
    #1 chk(master_diag, 32'hf1, "fault flag");
    rd(5'h01);
    chk(w, 32'h0, "data after fault");
    @(posedge clk) {init_error, structure_changed, short_circuit} <= 3'h0;
    {chain_fault, comm_error} <= 2'h0;
    repeat (3) @(posedge clk);
    #1 chk(master_diag, 32'h0, "flags cleared");
    $display("done diag");
  endtask
  task automatic t_teach;
    chk(teach_required, 32'h0, "stored match");
    @(posedge clk) config_stored <= 1'b0;
    #1 chk(teach_required, 32'h1, "first start");
    @(posedge clk) {config_stored, config_mismatch} <= 2'h3;
    #1 chk(teach_required, 32'h1, "mismatch");
    chk(function_indicator, 32'h1, "owed indicator");
    @(posedge clk) config_mismatch <= 1'b0;
    starts = 0;
    @(posedge clk) learn_button <= 1'b1;
    repeat (12) @(posedge clk);
    learn_button <= 1'b0;
    repeat (8) @(posedge clk);
    chk(starts, 32'h0, "short press");
    learn_button <= 1'b1;
    repeat (30) @(posedge clk);
    learn_button <= 1'b0;
    repeat (5) @(posedge clk);
    chk(starts, 32'h1, "long press");
    chk(teach_busy, 32'h1, "busy");
    flips = 0;
    teach_done <= 1'b1;
    @(posedge clk) teach_done <= 1'b0;
    repeat (40) @(posedge clk);
    chk(flips, 32'h6, "flash count");
    cfg_teach <= 1'b1;
    @(posedge clk) cfg_teach <= 1'b0;
    repeat (3) @(posedge clk);
    chk(starts, 32'h2, "config teach");
    teach_done <= 1'b1;
    @(posedge clk) teach_done <= 1'b0;
    $display("done teach");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {out_wr, resp_valid, resp_invalid, chain_fault, init_error, structure_changed} = '0;
    {short_circuit, comm_error, config_mismatch, teach_done, cfg_teach, cfg_direct} = '0;
    {learn_button, stall, out_node, in_node, resp_node, cfg_node} = '0;
    {resp_byte, resp_diag, gw_resp, cfg_byte, out_word, unreachable} = '0;
    config_stored = 1'b1;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_image();
    t_calls();
    t_diag();
    t_teach();
    close_out();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule
